// ===== include/bca_pkg.sv
// constants for the brake control and status access block
// assumes a frame decoder upstream delivers checked 32-bit frames
package bca_pkg;
    localparam int         ADDR_W          = 7;
    localparam int         DATA_W          = 16;
    localparam int         FRAME_W         = 32;
    localparam int         NUM_STAT        = 17;
    // frame field positions
    localparam int         FR_ACC_BIT      = 7;
    localparam int         FR_DATA_LSB     = 8;
    localparam int         FR_DATA_MSB     = 23;
    localparam int         FR_ADDR_LSB     = 0;
    localparam int         FR_ADDR_MSB     = 6;
    localparam int         FR_CRC_LSB      = 24;
    localparam int         FR_CRC_MSB      = 31;
    // addresses
    localparam logic [6:0] ADR_BRAKE       = 7'h1D;
    localparam logic [6:0] ADR_PROD_ID     = 7'h70;
    localparam logic [6:0] ADR_STAT [NUM_STAT] = '{
        7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46,
        7'h50, 7'h51, 7'h52, 7'h53, 7'h54, 7'h55,
        7'h57, 7'h58, 7'h59, 7'h70};
    // brake control fields
    localparam int         BRK_EXCL3       = 12;
    localparam int         BRK_EXCL2       = 11;
    localparam int         BRK_EXCL1       = 10;
    localparam int         BRK_RAPID       = 9;
    localparam int         BRK_VDS_TH      = 8;
    localparam int         BRK_BLANK       = 7;
    localparam int         BRK_PARK        = 6;
    localparam int         BRK_OV_EN       = 5;
    localparam int         BRK_LVL_MSB     = 2;
    localparam logic [15:0] BRK_RESET      = 16'h00A0;
    // bits kept across restart; 15:13 and 4:3 forced low
    localparam logic [15:0] BRK_KEEP_MASK  = 16'h1FE7;
    // bits that hold storage at all
    localparam logic [15:0] BRK_RW_MASK    = 16'h1FFF;
    // per-register rc mask index 16 is the identification word (all read-only)
    localparam logic [15:0] STAT_RC_DFLT   = 16'hFFFF;
    localparam logic [15:0] ZERO16         = 16'h0000;
endpackage

// ===== logic/bca_brake_status.sv
// brake control word and status-register read/clear engine
// assumes frames arrive with a one-cycle strobe and a crc verdict
`timescale 1ns/1ps

// What this block does
// - frame is address, access bit, two data bytes, crc
// - access bit low reads whole word unchanged
// - access bit high clears status word, payload ignored; brake word takes payload
// - status flags hold until cleared by command
// - register data sits in frame bits 8..23
// - read-only bits survive clears; rc bits clear
// - brake word decodes at address 0011101
// - bit 9 enables rapid low-side stop
// - bits 10..12 exclude low drivers from stop
// - bit 8 selects braking drain-source threshold
// - bit 7 selects braking blanking time
// - bit 6 enables parking brake, default off
// - bit 5 enables overvoltage brake, default on
// - reset loads 00A0; restart clears 15:13,4:3
// - status groups at 1000000, 1010000, 1110000
module bca_brake_status #(
    parameter logic [16*bca_pkg::NUM_STAT-1:0] RC_MASKS = {
        16'h0000, {16{bca_pkg::STAT_RC_DFLT}}},
    // identification word: value is arbitrary
    parameter logic [15:0] PROD_ID = 16'h5A00
) (
    input  wire logic                                  mclk,
    input  wire logic                                  srst,
    input  wire logic                                  restart,
    input  wire logic                                  frameValid,
    input  wire logic [bca_pkg::FRAME_W-1:0]           frameIn,
    input  wire logic                                  frameCrcOk,
    input  wire logic [16*bca_pkg::NUM_STAT-1:0]       statSet,
    input  wire logic [16*bca_pkg::NUM_STAT-1:0]       statLive,
    output logic                                       replyValid,
    output logic [bca_pkg::FRAME_W-1:0]                replyOut,
    output logic                                       rapidStopEn,
    output logic [2:0]                                 rapidStopExcludeLow,
    output logic                                       brakeDrainSourceThresholdSel,
    output logic                                       brakeBlankingTimeSel,
    output logic                                       parkingBrakeEnable,
    output logic                                       overvoltageBrakeEnable,
    output logic [2:0]                                 overvoltageBrakeLevel
);

    logic [15:0]                      brake_ff;
    logic [15:0]                      nxt_brake;
    logic [15:0]                      stat_ff [bca_pkg::NUM_STAT];
    logic [15:0]                      nxt_stat [bca_pkg::NUM_STAT];
    logic                             replyValid_ff;
    logic                             nxt_replyValid;
    logic [bca_pkg::FRAME_W-1:0]      replyOut_ff;
    logic [bca_pkg::FRAME_W-1:0]      nxt_replyOut;
    logic [6:0]                       addr;
    logic                             accClear;
    logic [15:0]                      payload;
    logic                             take;
    logic [bca_pkg::NUM_STAT-1:0]     hit;
    logic [15:0]                      rdData;
    logic                             brakeHit;

    assign addr     = frameIn[bca_pkg::FR_ADDR_MSB:bca_pkg::FR_ADDR_LSB];
    assign accClear = frameIn[bca_pkg::FR_ACC_BIT];
    assign payload  = frameIn[bca_pkg::FR_DATA_MSB:bca_pkg::FR_DATA_LSB];
    // a corrupt frame may carry any address, so nothing is touched
    assign take     = frameValid && frameCrcOk;
    assign brakeHit = (addr == bca_pkg::ADR_BRAKE);

    // status words: hardware sets, software clears whole word
    genvar gi;
    generate
        for (gi = 0; gi < bca_pkg::NUM_STAT; gi++)
        begin : g_stat
            localparam logic [15:0] RC = RC_MASKS[16*gi +: 16];
            assign hit[gi] = (addr == bca_pkg::ADR_STAT[gi]);
            always_comb
            begin
                nxt_stat[gi] = stat_ff[gi];
                if (take && accClear && hit[gi])
                begin
                    nxt_stat[gi] = stat_ff[gi] & ~RC;
                end
                // set wins over a clear landing in the same cycle
                nxt_stat[gi] = (nxt_stat[gi] | (statSet[16*gi +: 16] & RC))
                             & RC;
            end
            always_ff @(posedge mclk)
            begin
                if (srst)
                    stat_ff[gi] <= bca_pkg::ZERO16;
                else
                    stat_ff[gi] <= nxt_stat[gi];
            end
        end
    endgenerate

    // read mux: rc bits from storage, read-only bits live from their source
    always_comb
    begin
        rdData = bca_pkg::ZERO16;
        if (brakeHit)
            rdData = brake_ff & bca_pkg::BRK_RW_MASK;
        else if (addr == bca_pkg::ADR_PROD_ID)
            rdData = PROD_ID;
        else
        begin
            for (int i = 0; i < bca_pkg::NUM_STAT; i++)
            begin
                if (hit[i])
                    rdData = stat_ff[i] | (statLive[16*i +: 16] & ~RC_MASKS[16*i +: 16]);
            end
        end
    end

    // brake word write; clear-access carries the new value
    always_comb
    begin
        nxt_brake = brake_ff;
        if (restart)
            nxt_brake = brake_ff & bca_pkg::BRK_KEEP_MASK;
        else if (take && accClear && brakeHit)
            nxt_brake = payload & bca_pkg::BRK_RW_MASK;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            brake_ff <= bca_pkg::BRK_RESET;
        else
            brake_ff <= nxt_brake;
    end

    // reply holds the pre-clear word so a clear still reports what it erased
    always_comb
    begin
        nxt_replyValid = take;
        nxt_replyOut   = replyOut_ff;
        if (take)
        begin
            nxt_replyOut = {frameIn[bca_pkg::FR_CRC_MSB:bca_pkg::FR_CRC_LSB],
                            rdData, frameIn[7:0]};
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            replyValid_ff <= 1'b0;
            replyOut_ff   <= 32'h0000_0000;
        end
        else
        begin
            replyValid_ff <= nxt_replyValid;
            replyOut_ff   <= nxt_replyOut;
        end
    end

    assign replyValid                   = replyValid_ff;
    assign replyOut                     = replyOut_ff;
    assign rapidStopEn                  = brake_ff[bca_pkg::BRK_RAPID];
    assign rapidStopExcludeLow          = brake_ff[bca_pkg::BRK_EXCL3:bca_pkg::BRK_EXCL1];
    assign brakeDrainSourceThresholdSel = brake_ff[bca_pkg::BRK_VDS_TH];
    assign brakeBlankingTimeSel         = brake_ff[bca_pkg::BRK_BLANK];
    assign parkingBrakeEnable           = brake_ff[bca_pkg::BRK_PARK];
    assign overvoltageBrakeEnable       = brake_ff[bca_pkg::BRK_OV_EN];
    assign overvoltageBrakeLevel        = brake_ff[bca_pkg::BRK_LVL_MSB:0];

endmodule

// ===== test/bca_mcu_model.sv
// microcontroller model: presents one frame per send; assumes a rising-edge block
`timescale 1ns/1ps
module bca_mcu_model (
    input  wire logic   mclk,
    output logic        frameValid = 1'b0,
    output logic [31:0] frameIn = 32'h0,
    output logic        frameCrcOk = 1'b0
);
    task automatic send(logic [6:0] a, logic c, logic [15:0] d, logic k);
        @(negedge mclk);
        frameIn = {d[15:8] ^ d[7:0], d, c, a};
        frameCrcOk = k;
        frameValid = 1'b1;
        @(negedge mclk);
        frameValid = 1'b0;
        frameIn = ~frameIn; // released bus must not look like a stale frame
    endtask
endmodule

// ===== test/bca_chk.sv
// assertion checker bound to the brake and status block; sees only its ports
`timescale 1ns/1ps
module bca_chk (
    input wire logic        mclk,
    input wire logic        srst,
    input wire logic        frameValid,
    input wire logic [31:0] frameIn,
    input wire logic        frameCrcOk,
    input wire logic        replyValid,
    input wire logic [31:0] replyOut,
    input wire logic [2:0]  overvoltageBrakeLevel
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    sequence s_take; frameValid && frameCrcOk; endsequence
    sequence s_brkWr; s_take ##0 frameIn[7:0] == 8'h9D; endsequence
    property p_reply; s_take |=> replyValid; endproperty
    a_reply: assert property (p_reply) else $error("no reply");
    property p_quiet; !(frameValid && frameCrcOk) |=> !replyValid && $stable(replyOut); endproperty
    a_quiet: assert property (p_quiet) else $error("reply without frame");
    property p_echo; s_take |=> replyOut[7:0] == $past(frameIn[7:0]); endproperty
    a_echo: assert property (p_echo) else $error("header echo wrong");
    property p_lvl; s_brkWr |=> overvoltageBrakeLevel == $past(frameIn[10:8]); endproperty
    a_lvl: assert property (p_lvl) else $error("trip level not written");
    property p_rsv; s_take ##0 frameIn[7:0] == 8'h1D |=> replyOut[23:21] == 3'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
    property p_bad; frameValid && !frameCrcOk |=> $stable(overvoltageBrakeLevel); endproperty
    a_bad: assert property (p_bad) else $error("bad frame changed brake");
    property p_rd; s_take ##0 !frameIn[7] |=> $stable(overvoltageBrakeLevel); endproperty
    a_rd: assert property (p_rd) else $error("read changed brake");
    property p_rst; $fell(srst) |-> replyOut == 32'h0 && overvoltageBrakeLevel == 3'h0; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
bind bca_brake_status bca_chk i_bca_chk(.mclk(mclk), .srst(srst), .frameValid(frameValid),
    .frameIn(frameIn), .frameCrcOk(frameCrcOk), .replyValid(replyValid), .replyOut(replyOut),
    .overvoltageBrakeLevel(overvoltageBrakeLevel));

// ===== test/brake_cfg_and_status_access_bench.sv
// self-checking bench for the brake and status block; frames come from the mcu model
`timescale 1ns/1ps
module brake_cfg_and_status_access_bench;
    logic        mclk = 1'b0, srst = 1'b1, restart = 1'b0, frameValid, frameCrcOk, replyValid;
    logic [31:0] frameIn, replyOut;
    logic [15:0] w;
    logic [10:0] brkOut;
    logic [16*bca_pkg::NUM_STAT-1:0] statSet = '0;
    int          failures = 0, testsRun = 0;
    always #25 mclk = ~mclk;
    bca_mcu_model i_bca_mcu_model(.mclk(mclk), .frameValid(frameValid), .frameIn(frameIn),
        .frameCrcOk(frameCrcOk));
    bca_brake_status i_bca_brake_status(.mclk(mclk), .srst(srst), .restart(restart),
        .frameValid(frameValid), .frameIn(frameIn), .frameCrcOk(frameCrcOk), .statSet(statSet),
        .statLive('0), .replyValid(replyValid), .replyOut(replyOut),
        .rapidStopEn(brkOut[10]), .rapidStopExcludeLow(brkOut[9:7]),
        .brakeDrainSourceThresholdSel(brkOut[6]), .brakeBlankingTimeSel(brkOut[5]),
        .parkingBrakeEnable(brkOut[4]), .overvoltageBrakeEnable(brkOut[3]),
        .overvoltageBrakeLevel(brkOut[2:0]));
    function automatic logic [15:0] kept(logic [15:0] x);
        return x & 16'h1FE7;
    endfunction
    // field outputs expected from a brake word value
    function automatic logic [10:0] outs(logic [15:0] v);
        return {v[9], v[12:10], v[8], v[7], v[6], v[5], v[2:0]};
    endfunction
    task automatic chk_brk(logic [15:0] v);
        testsRun++;
        if (brkOut !== outs(v))
        begin
            failures++;
            $display("Error brake outputs expected %h seen %h", outs(v), brkOut);
        end
    endtask
    // reply stands for one cycle only, so it is looked at right after the frame
    task automatic xf(logic [6:0] a, logic c, logic [15:0] d, logic k, logic [15:0] e);
        i_bca_mcu_model.send(a, c, d, k);
        testsRun++;
        if ({replyValid, replyOut[23:8]} !== {k, e})
            $display("Error reg %h expected %h seen %h", a, {k, e}, {replyValid, replyOut[23:8]});
        failures += ({replyValid, replyOut[23:8]} !== {k, e}) ? 1 : 0;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d failures %0d", testsRun, failures);
        if (failures == 0 && testsRun > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #150000 failures++;
        give_verdict();
    end
    initial
    begin
        void'($urandom(32'h137B0C9E));
        repeat (5) @(negedge mclk);
        srst = 1'b0;
        xf(bca_pkg::ADR_BRAKE, 1'b0, 16'hFFFF, 1'b1, bca_pkg::BRK_RESET);
        chk_brk(bca_pkg::BRK_RESET);
        i_bca_mcu_model.send(bca_pkg::ADR_BRAKE, 1'b1, 16'hFFFF, 1'b1);
        chk_brk(16'h1FFF);
        for (int i = 0; i < 16; i++)
        begin
            restart = (i == 7);
            w = 16'($urandom) | 16'h8001;
            statSet[16*i +: 16] = w;
            xf(bca_pkg::ADR_STAT[i], 1'b0, 16'h0, 1'b1, w);
            statSet = '0;
            xf(bca_pkg::ADR_STAT[i], 1'b1, 16'($urandom), i != 5, w);
            xf(bca_pkg::ADR_STAT[i], 1'b0, 16'h0, 1'b1, (i == 5) ? w : 16'h0);
        end
        xf(bca_pkg::ADR_BRAKE, 1'b0, 16'h0, 1'b1, kept(16'hFFFF));
        chk_brk(16'h1FE7);
        xf(7'h00, 1'b0, 16'h0, 1'b1, 16'h0);
        repeat (4)
        begin
            w = 16'($urandom) & 16'h1FE7;
            i_bca_mcu_model.send(bca_pkg::ADR_BRAKE, 1'b1, w, 1'b1);
            chk_brk(w);
            i_bca_mcu_model.send(bca_pkg::ADR_BRAKE, 1'b1, ~w, 1'b0);
            chk_brk(w);
            xf(bca_pkg::ADR_BRAKE, 1'b0, 16'($urandom), 1'b1, w);
        end
        give_verdict();
    end
endmodule
